/* design/cie_top.v */
// CAN irq enables, transmit empty flags and abort logic, Wishbone slave
// Contract
// - Rx irq enable reset and locked in init
// - Sensitivity fields survive init mode
// - Wake enable gates wake event to irq
// - Status change enable gates error irq
// - Rx state sensitivity filters flag setting
// - Tx state sensitivity filters flag setting
// - State indicators update only when flag clear
// - Overrun enable gates error irq
// - Rx full enable gates receive irq
// - Rx bus-off follows tx, recovers with tx
// - Empty flags write-one-clear, reset in init
// - Flag set again on sent or aborted
// - Transmit irq while empty and enabled
// - Clear empty clears ack; set clears request
// - Listen-only refuses clearing, blocks start
// - Block buffer access while scheduled
// - Bits 7-3 of tx registers read zero
// - Abort granted only before start or failure
// - Granted abort sets empty and ack
// - Software cannot clear abort request
// - Ack tells aborted from sent
// - Tx enable, request, ack reset in init
// - Tx state encodes error count thresholds
// - Flag set on bus state change
`timescale 1ns/1ps
`include "cie_map.vh"
module cie_top (
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // Wishbone slave
   input  wire       wb_cyc_i,
   input  wire       wb_stb_i,
   input  wire       wb_we_i,
   input  wire [3:0] wb_adr_i,
   input  wire [7:0] wb_dat_i,
   output reg  [7:0] wb_dat_o,
   output reg        wb_ack_o,
   // Mode handshake
   output reg        init_request_o,
   input  wire       init_ack_i,
   output reg        listen_only_o,
   // Receive side flags and error counters
   input  wire       wake_flag_i,
   input  wire       overrun_flag_i,
   input  wire       rx_frame_ready_i,
   input  wire [8:0] tx_err_cnt_i,
   input  wire [8:0] rx_err_cnt_i,
   // Transmit engine
   input  wire [2:0] tx_sent_i,
   input  wire [2:0] tx_abort_ok_i,
   output reg  [2:0] tx_pending_o,
   output reg  [2:0] abort_request_o,
   output reg  [2:0] buf_blocked_o,
   // Interrupts
   output reg        wake_irq_o,
   output reg        err_irq_o,
   output reg        rx_irq_o,
   output reg        tx_irq_o
);
   localparam NB = `CIE_NBUF;

   reg  [7:0]    rx_irq_en_r;
   reg  [1:0]    sens_rx_r;
   reg  [1:0]    sens_tx_r;
   reg           bsc_flag_r;
   reg  [1:0]    rx_bus_state_r;
   reg  [1:0]    tx_bus_state_r;
   reg  [NB-1:0] tx_slot_empty_r;
   reg  [NB-1:0] tx_irq_en_r;
   reg  [NB-1:0] abort_req_r;
   reg  [NB-1:0] abort_ack_r;
   reg  [2:0]    wake_s_r;
   reg  [2:0]    ovr_s_r;
   reg  [2:0]    rxf_s_r;
   reg           wake_m_r;
   reg           ovr_m_r;
   reg           rxf_m_r;
   reg  [7:0]    rd_nxt;
   wire [1:0]    tx_raw;
   wire [1:0]    rx_raw;
   wire          in_init;
   wire          wr;
   wire          rx_chg;
   wire          tx_chg;
   wire [NB-1:0] clr_req;
   wire [NB-1:0] set_empty;

   cie_state_enc u_enc (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .tx_err_cnt_i (tx_err_cnt_i),
      .rx_err_cnt_i (rx_err_cnt_i),
      .tx_raw_o     (tx_raw),
      .rx_raw_o     (rx_raw)
   );

   // Sensitivity test: does a move old->new count
   function hit;
      input [1:0] sens;
      input [1:0] o;
      input [1:0] n;
      begin
         case (sens)
            2'b01:   hit = (o == `CIE_ST_BOFF) != (n == `CIE_ST_BOFF);
            2'b10:   hit = (o[1]) != (n[1]);
            2'b11:   hit = (o != n);
            default: hit = 1'b0;
         endcase
      end
   endfunction

   assign in_init = init_request_o & init_ack_i;
   assign wr      = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign rx_chg  = hit(sens_rx_r, rx_bus_state_r, rx_raw);
   assign tx_chg  = hit(sens_tx_r, tx_bus_state_r, tx_raw);
   assign clr_req = (wr && wb_adr_i == `CIE_IDX_TX_EMPTY && !listen_only_o)
                    ? wb_dat_i[NB-1:0] : {NB{1'b0}};

   // Pin-side flags: three stages, change taken when last two agree
   always @(posedge clk_i) begin
      if (rst_i) begin
         wake_s_r <= 3'b000;
         ovr_s_r  <= 3'b000;
         rxf_s_r  <= 3'b000;
         wake_m_r <= 1'b0;
         ovr_m_r  <= 1'b0;
         rxf_m_r  <= 1'b0;
      end else begin
         wake_s_r <= {wake_s_r[1:0], wake_flag_i};
         ovr_s_r  <= {ovr_s_r[1:0], overrun_flag_i};
         rxf_s_r  <= {rxf_s_r[1:0], rx_frame_ready_i};
         wake_m_r <= (wake_s_r[2] == wake_s_r[1]) ? wake_s_r[2] : wake_m_r;
         ovr_m_r  <= (ovr_s_r[2] == ovr_s_r[1]) ? ovr_s_r[2] : ovr_m_r;
         rxf_m_r  <= (rxf_s_r[2] == rxf_s_r[1]) ? rxf_s_r[2] : rxf_m_r;
      end
   end

   // Control register and status change flag
   always @(posedge clk_i) begin
      if (rst_i) begin
         init_request_o <= 1'b1;
         listen_only_o  <= 1'b0;
         rx_irq_en_r    <= `CIE_RST_RX_IRQ_EN;
         sens_rx_r      <= 2'b00;
         sens_tx_r      <= 2'b00;
         bsc_flag_r     <= 1'b0;
         rx_bus_state_r <= `CIE_ST_OK;
         tx_bus_state_r <= `CIE_ST_OK;
      end else begin
         if (wr && wb_adr_i == `CIE_IDX_CTRL) begin
            listen_only_o  <= wb_dat_i[`CIE_BIT_CTRL_LISTEN];
            init_request_o <= wb_dat_i[`CIE_BIT_CTRL_INIT_REQUEST];
         end
         if (in_init) begin
            rx_irq_en_r <= `CIE_RST_RX_IRQ_EN;
         end else if (wr && wb_adr_i == `CIE_IDX_RX_IRQ_EN) begin
            rx_irq_en_r <= wb_dat_i;
            sens_rx_r   <= wb_dat_i[`CIE_FLD_RX_SENS_HI:`CIE_FLD_RX_SENS_LO];
            sens_tx_r   <= wb_dat_i[`CIE_FLD_TX_SENS_HI:`CIE_FLD_TX_SENS_LO];
         end
         // Sensitivity kept apart so init cannot touch it
         // States frozen while the flag is pending
         if (!bsc_flag_r) begin
            rx_bus_state_r <= rx_raw;
            tx_bus_state_r <= tx_raw;
            if (rx_chg || tx_chg)
               bsc_flag_r <= 1'b1;
         end else if (!in_init && wr && wb_adr_i == `CIE_IDX_STATUS &&
                      wb_dat_i[`CIE_BIT_FLAG_BSC]) begin
            bsc_flag_r <= 1'b0;
         end
         if (in_init)
            bsc_flag_r <= 1'b0;
      end
   end

   // Per-buffer transmit flags
   genvar g;
   generate
      for (g = 0; g < NB; g = g + 1) begin : g_buf
         assign set_empty[g] = tx_sent_i[g] |
                               (tx_abort_ok_i[g] & abort_req_r[g]);
         always @(posedge clk_i) begin
            if (rst_i || in_init) begin
               tx_slot_empty_r[g] <= 1'b1;
               tx_irq_en_r[g]     <= 1'b0;
               abort_req_r[g]     <= 1'b0;
               abort_ack_r[g]     <= 1'b0;
            end else begin
               if (wr && wb_adr_i == `CIE_IDX_TX_IRQ_EN)
                  tx_irq_en_r[g] <= wb_dat_i[g];
               if (set_empty[g]) begin
                  tx_slot_empty_r[g] <= 1'b1;
                  abort_req_r[g]     <= 1'b0;
                  abort_ack_r[g]     <= ~tx_sent_i[g];
               end else if (clr_req[g]) begin
                  tx_slot_empty_r[g] <= 1'b0;
                  abort_ack_r[g]     <= 1'b0;
               end else if (wr && wb_adr_i == `CIE_IDX_ABORT_REQ &&
                            wb_dat_i[g] && !tx_slot_empty_r[g]) begin
                  abort_req_r[g] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // Read mux, bits 7-3 of tx registers zero
   always @* begin
      rd_nxt = 8'h00;
      case (wb_adr_i)
         `CIE_IDX_STATUS:
            rd_nxt = {1'b0, bsc_flag_r, rx_bus_state_r, tx_bus_state_r,
                      2'b00};
         `CIE_IDX_RX_IRQ_EN:
            rd_nxt = {rx_irq_en_r[7:6], sens_rx_r, sens_tx_r,
                      rx_irq_en_r[1:0]};
         `CIE_IDX_TX_EMPTY:  rd_nxt = {5'h00, tx_slot_empty_r};
         `CIE_IDX_TX_IRQ_EN: rd_nxt = {5'h00, tx_irq_en_r};
         `CIE_IDX_ABORT_REQ: rd_nxt = {5'h00, abort_req_r};
         `CIE_IDX_ABORT_ACK: rd_nxt = {5'h00, abort_ack_r};
         `CIE_IDX_CTRL:
            rd_nxt = {5'h00, in_init, init_request_o, listen_only_o};
         default:            rd_nxt = 8'h00;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o        <= 1'b0;
         wb_dat_o        <= 8'h00;
         tx_pending_o    <= 3'h0;
         abort_request_o <= 3'h0;
         buf_blocked_o   <= 3'h0;
         wake_irq_o      <= 1'b0;
         err_irq_o       <= 1'b0;
         rx_irq_o        <= 1'b0;
         tx_irq_o        <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= rd_nxt;
         tx_pending_o <= listen_only_o ? 3'h0 : ~tx_slot_empty_r;
         abort_request_o <= abort_req_r;
         buf_blocked_o   <= ~tx_slot_empty_r;
         wake_irq_o <= wake_m_r & rx_irq_en_r[`CIE_BIT_WAKE_IE];
         err_irq_o  <= (bsc_flag_r & rx_irq_en_r[`CIE_BIT_BSC_IE]) |
                       (ovr_m_r & rx_irq_en_r[`CIE_BIT_OVR_IE]);
         rx_irq_o   <= rxf_m_r & rx_irq_en_r[`CIE_BIT_RXF_IE];
         tx_irq_o   <= |(tx_slot_empty_r & tx_irq_en_r);
      end
   end
endmodule

/* inc/cie_map.vh */
// Register offsets, field positions and reset values for the CAN irq block
`ifndef CIE_MAP_VH
`define CIE_MAP_VH
`define CIE_IDX_RX_IRQ_EN    4'h5
`define CIE_IDX_TX_EMPTY     4'h6
`define CIE_IDX_TX_IRQ_EN    4'h7
`define CIE_IDX_ABORT_REQ    4'h8
`define CIE_IDX_ABORT_ACK    4'h9
`define CIE_IDX_STATUS       4'h4
`define CIE_IDX_CTRL         4'hc
`define CIE_RST_RX_IRQ_EN    8'h00
`define CIE_RST_TX_EMPTY     3'h7
`define CIE_RST_TX_IRQ_EN    3'h0
`define CIE_RST_ABORT        3'h0
`define CIE_BIT_WAKE_IE      7
`define CIE_BIT_BSC_IE       6
`define CIE_BIT_OVR_IE       1
`define CIE_BIT_RXF_IE       0
`define CIE_FLD_RX_SENS_HI   5
`define CIE_FLD_RX_SENS_LO   4
`define CIE_FLD_TX_SENS_HI   3
`define CIE_FLD_TX_SENS_LO   2
`define CIE_BIT_FLAG_BSC     6
`define CIE_BIT_CTRL_LISTEN  0
`define CIE_BIT_CTRL_INIT_REQUEST  1
`define CIE_NBUF             3
`define CIE_CNT_WARN         9'd96
`define CIE_CNT_ERR          9'd128
`define CIE_CNT_BOFF         9'd256
`define CIE_ST_OK            2'b00
`define CIE_ST_WARN          2'b01
`define CIE_ST_ERR           2'b10
`define CIE_ST_BOFF          2'b11
`endif

/* design/cie_state_enc.v */
// Error counter to bus state encoder, registered
`timescale 1ns/1ps
`include "cie_map.vh"
module cie_state_enc (
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // Counters
   input  wire [8:0] tx_err_cnt_i,
   input  wire [8:0] rx_err_cnt_i,
   // Raw states
   output reg  [1:0] tx_raw_o,
   output reg  [1:0] rx_raw_o
);
   function [1:0] enc;
      input [8:0] c;
      begin
         if (c >= `CIE_CNT_BOFF)
            enc = `CIE_ST_BOFF;
         else if (c >= `CIE_CNT_ERR)
            enc = `CIE_ST_ERR;
         else if (c >= `CIE_CNT_WARN)
            enc = `CIE_ST_WARN;
         else
            enc = `CIE_ST_OK;
      end
   endfunction

   always @(posedge clk_i) begin
      if (rst_i) begin
         tx_raw_o <= `CIE_ST_OK;
         rx_raw_o <= `CIE_ST_OK;
      end else begin
         tx_raw_o <= enc(tx_err_cnt_i);
         // Receiver mirrors bus-off of the transmitter
         if (enc(tx_err_cnt_i) == `CIE_ST_BOFF)
            rx_raw_o <= `CIE_ST_BOFF;
         else if (enc(rx_err_cnt_i) == `CIE_ST_BOFF)
            rx_raw_o <= `CIE_ST_ERR;
         else
            rx_raw_o <= enc(rx_err_cnt_i);
      end
   end
endmodule

/* sim/cie_engine_model.sv */
// Transmit engine model: init handshake, sending and abort grants
`timescale 1ns/1ps
module cie_engine_model (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        hold_i,
   input  wire        init_request_i,
   input  wire  [2:0] tx_pending_i,
   input  wire  [2:0] abort_request_i,
   output logic       init_ack_o = 1'b1,
   output logic [2:0] tx_sent_o = 3'h0,
   output logic [2:0] tx_abort_ok_o = 3'h0
);
   logic [3:0] cnt = 4'h0;
   wire  [2:0] want = abort_request_i & tx_pending_i;
   wire  [2:0] low = tx_pending_i & ~(tx_pending_i - 3'h1);
   wire        go = !rst_i && tx_pending_i != 3'h0 && !hold_i;
   wire        abt = go && want != 3'h0 && !cnt[3];
   always @(posedge clk_i) begin
      init_ack_o <= rst_i | init_request_i;
      tx_abort_ok_o <= abt ? want : 3'h0;
      // Lowest pending buffer goes out once the frame time ends
      tx_sent_o <= (go && !abt && cnt == 4'hf) ? low : 3'h0;
      if (rst_i || tx_pending_i == 3'h0)
         cnt <= 4'h0;
      else if (go && !abt)
         cnt <= cnt + 4'h1;
   end
endmodule

/* sim/cie_top_checker.sv */
// Port assertions for the CAN irq enable and transmit abort block
`timescale 1ns/1ps
module cie_top_checker (
   // Clock, reset and bus
   input wire       clk_i,
   input wire       rst_i,
   input wire       wb_cyc_i,
   input wire       wb_stb_i,
   input wire       wb_ack_o,
   // Mode and engine
   input wire       init_request_o,
   input wire       init_ack_i,
   input wire       listen_only_o,
   input wire [2:0] tx_sent_i,
   input wire [2:0] tx_abort_ok_i,
   input wire [2:0] tx_pending_o,
   input wire [2:0] abort_request_o,
   input wire [2:0] buf_blocked_o,
   // Interrupts
   input wire       wake_irq_o,
   input wire       err_irq_o,
   input wire       rx_irq_o,
   input wire       tx_irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire        in_init = init_request_o && init_ack_i;
   logic       lst_q;
   logic [2:0] blk_q;
   always @(posedge clk_i) begin
      lst_q <= listen_only_o;
      blk_q <= buf_blocked_o;
   end
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("bus ack missing");
   property p_lst; listen_only_o && lst_q |-> ~|tx_pending_o; endproperty
   a_lst: assert property (p_lst) else $error("pending in listen");
   property p_blk; !listen_only_o && !lst_q |-> tx_pending_o == buf_blocked_o;
   endproperty
   a_blk: assert property (p_blk) else $error("block mismatch");
   property p_arq; ~|(abort_request_o & ~buf_blocked_o & ~blk_q); endproperty
   a_arq: assert property (p_arq) else $error("request on empty");
   property p_init; in_init [*3] |-> ~|{abort_request_o, buf_blocked_o, tx_irq_o};
   endproperty
   a_init: assert property (p_init) else $error("tx not held");
   property p_rinit; in_init [*3] |-> !(wake_irq_o || err_irq_o || rx_irq_o);
   endproperty
   a_rinit: assert property (p_rinit) else $error("rx irq in init");
   property p_sent; tx_sent_i[0] && buf_blocked_o[0] |-> ##[1:3] !buf_blocked_o[0];
   endproperty
   a_sent: assert property (p_sent) else $error("sent not empty");
   property p_abt;
      tx_abort_ok_i[0] && abort_request_o[0] |-> ##[1:3] !buf_blocked_o[0];
   endproperty
   a_abt: assert property (p_abt) else $error("abort not empty");
   c_abort: cover property (tx_abort_ok_i[0] && abort_request_o[0]);
   c_sent: cover property (tx_sent_i[0] && buf_blocked_o[0]);
   c_listen: cover property (listen_only_o && lst_q);
endmodule
bind cie_top cie_top_checker i_cie_top_checker (.*);

/* sim/cie_top_tb.sv */
// Testbench for the CAN irq enable and transmit abort block
`timescale 1ns/1ps
module cie_top_tb;
   logic       clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic       wb_we_i = 1'b0, hold = 1'b0, wake_flag_i = 1'b0;
   logic       overrun_flag_i = 1'b0, rx_frame_ready_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [7:0] wb_dat_i = 8'h00, q;
   logic [8:0] tx_err_cnt_i = 9'h000, rx_err_cnt_i = 9'h000;
   wire  [7:0] wb_dat_o;
   wire        wb_ack_o, init_request_o, init_ack_i, listen_only_o;
   wire        wake_irq_o, err_irq_o, rx_irq_o, tx_irq_o;
   wire  [2:0] tx_sent_i, tx_abort_ok_i, tx_pending_o, abort_request_o;
   wire  [2:0] buf_blocked_o;
   wire  [7:0] irqv = {5'h00, wake_irq_o, err_irq_o, rx_irq_o};
   int         n_errors = 0, n_checks = 0, cyc = 0;
   cie_top i_cie_top (.*);
   cie_engine_model i_cie_engine_model (.clk_i(clk_i), .rst_i(rst_i),
      .hold_i(hold), .init_request_i(init_request_o), .init_ack_o(init_ack_i),
      .tx_pending_i(tx_pending_o), .abort_request_i(abort_request_o),
      .tx_sent_o(tx_sent_i), .tx_abort_ok_o(tx_abort_ok_i));
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_errors++;
         wrap_up;
      end
   end
   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), q, e);
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b1, 4'h5, 8'hff);
      wb(1'b1, 4'h8, 8'hff);
      for (int i = 5; i < 10; i++)
         rd(4'(i), (i == 6) ? 8'h07 : 8'h00);
      wb(1'b1, 4'hc, 8'h00);
      wb(1'b1, 4'h5, 8'hfc);
      wb(1'b1, 4'hc, 8'h02);
      rd(4'h5, 8'h3c);
      $display("test init done");
      wb(1'b1, 4'hc, 8'h00);
      wb(1'b1, 4'h5, 8'h83);
      for (int i = 0; i < 3; i++) begin
         {wake_flag_i, overrun_flag_i, rx_frame_ready_i} <= 3'h1 << i;
         repeat (10) @(posedge clk_i);
         chk("irq", irqv, 8'h01 << i);
      end
      $display("test enables done");
      {wake_flag_i, overrun_flag_i, rx_frame_ready_i} <= 3'h0;
      wb(1'b1, 4'h5, 8'h4c);
      tx_err_cnt_i <= 9'h100;
      repeat (8) @(posedge clk_i);
      rd(4'h4, 8'h7c);
      chk("err irq", irqv, 8'h02);
      tx_err_cnt_i <= 9'h000;
      repeat (8) @(posedge clk_i);
      rd(4'h4, 8'h7c);
      wb(1'b1, 4'h4, 8'h40);
      repeat (8) @(posedge clk_i);
      rd(4'h4, 8'h40);
      wb(1'b1, 4'h4, 8'h40);
      wb(1'b1, 4'h5, 8'h00);
      tx_err_cnt_i <= 9'h064;
      repeat (8) @(posedge clk_i);
      rd(4'h4, 8'h04);
      wb(1'b1, 4'h5, 8'h50);
      rx_err_cnt_i <= 9'h080;
      repeat (8) @(posedge clk_i);
      rd(4'h4, 8'h24);
      chk("no err irq", irqv, 8'h00);
      wb(1'b1, 4'h5, 8'h60);
      rx_err_cnt_i <= 9'h000;
      repeat (8) @(posedge clk_i);
      rd(4'h4, 8'h44);
      chk("rx err irq", irqv, 8'h02);
      wb(1'b1, 4'h4, 8'h40);
      wb(1'b1, 4'h5, 8'h00);
      $display("test bus state done");
      hold <= 1'b1;
      wb(1'b1, 4'h7, 8'hff);
      rd(4'h7, 8'h07);
      chk("tx irq", {7'h00, tx_irq_o}, 8'h01);
      wb(1'b1, 4'h6, 8'hf9);
      wb(1'b1, 4'h8, 8'hff);
      wb(1'b1, 4'h8, 8'h00);
      rd(4'h6, 8'h06);
      rd(4'h8, 8'h01);
      chk("pend", {2'h0, tx_pending_o, buf_blocked_o}, 8'h09);
      hold <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(4'h6, 8'h07);
      rd(4'h9, 8'h01);
      rd(4'h8, 8'h00);
      wb(1'b1, 4'h6, 8'h01);
      rd(4'h9, 8'h00);
      for (int i = 0; i < 99 && tx_pending_o !== 3'h0; i++) @(posedge clk_i);
      rd(4'h6, 8'h07);
      rd(4'h9, 8'h00);
      wb(1'b1, 4'hc, 8'h01);
      wb(1'b1, 4'h6, 8'h07);
      rd(4'h6, 8'h07);
      rd(4'ha, 8'h00);
      $display("test transmit done");
      wrap_up;
   end
endmodule
